// file: hdl/bridge_header_ctrl_regs.sv
/*
 * configuration registers 30h..3Ch of a switch port's bridge header, plus the
 * decode and gating logic steered by the bridge control word.
 * assumes one clock, configuration accesses arriving as single-cycle requests
 * from the upstream host, and window low halves supplied by neighbouring regs.
 */
// Behaviour
// R1 - 16-bit RW i/o window base bits 31:16 at 30h[15:0], reset zero.
// R2 - 16-bit RW i/o window limit bits 31:16 at 30h[31:16], reset zero.
// R3 - capability pointer reads 40h, read-only.
// R4 - interrupt pin RO in bits 15:8, reset zero, sideband load may override.
// R5 - bit 16 clear ignores secondary poisoned TLPs; set reports them.
// R6 - bit 17 gates forwarding of secondary error messages upstream, reset zero.
// R7 - bit 18 set sends window i/o in the top 768 bytes of each 1KB of the first 64KB upstream, unless VGA claims it.
// R8 - bit 19 set forwards memory accesses A0000h..BFFFFh.
// R9 - with VGA on, low-64KB i/o at 3B0h-3BBh or 3C0h-3DFh forwarded.
// R10 - bit 20 selects 10-bit (clear) or 16-bit (set) VGA i/o decode.
// R11 - secondary bus reset bit triggers hot reset on this port, reset zero.
// R12 - on upstream port, that bit resets every downstream port.
// R13 - legacy bits 21 and 23..27 read-only, always zero.
// R14 - interrupt line byte is plain RW storage, reset zero.
// R15 - reserved bits 31:28 read zero, unaffected by writes.
`timescale 1ns/10ps
`default_nettype none

module bridge_header_ctrl_regs (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// configuration access from upstream host
	input  wire logic        cfgReq,
	input  wire logic        cfgWrite,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [3:0]  cfgByteEn,
	input  wire logic [31:0] cfgWrData,
	output logic             cfgAck,
	output logic [31:0]      cfgRdData,
	// sideband / serial memory load of interrupt pin
	input  wire logic        pinLoadValid,
	input  wire logic [7:0]  pinLoadValue,
	// port role and window low halves
	input  wire logic        isUpstreamPort,
	input  wire logic [15:0] ioBaseLow,
	input  wire logic [15:0] ioLimitLow,
	// forwarding decode request
	input  wire logic        ioReqValid,
	input  wire logic [31:0] ioReqAddr,
	input  wire logic        memReqValid,
	input  wire logic [31:0] memReqAddr,
	output logic             ioForwardDown,
	output logic             ioForwardUp,
	output logic             vgaMemForward,
	// secondary side events
	input  wire logic        poisonedSeen,
	input  wire logic        errMsgSeen,
	output logic             poisonReport,
	output logic             errMsgForward,
	// hot reset outputs
	output logic                                          hotResetReq,
	output logic [bridge_header_ctrl_pkg::NUM_DOWN_PORTS-1:0] downPortReset_n
);

	// ***********************************************
	// storage
	// ***********************************************
	logic [15:0] ioBaseHigh_r;
	logic [15:0] ioLimitHigh_r;
	logic [7:0]  intLine_r;
	logic [7:0]  intPin_r;
	logic        poisonResp_r;
	logic        errFwd_r;
	logic        isaEn_r;
	logic        vgaEn_r;
	logic        vgaDec16_r;
	logic        secReset_r;
	logic [31:0] ctrlWord;
	logic [31:0] rdData_nxt;
	logic        wrIo;
	logic        wrIntBr;

	assign wrIo    = cfgReq && cfgWrite && (cfgAddr == bridge_header_ctrl_pkg::OFF_IO_WINDOW_HIGH);
	assign wrIntBr = cfgReq && cfgWrite && (cfgAddr == bridge_header_ctrl_pkg::OFF_INT_BRIDGE);

	// R1 window base high
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioBaseHigh_r <= bridge_header_ctrl_pkg::RST_IO_BASE_HIGH;
		end else if (wrIo) begin
			if (cfgByteEn[0]) ioBaseHigh_r[7:0]  <= cfgWrData[7:0];
			if (cfgByteEn[1]) ioBaseHigh_r[15:8] <= cfgWrData[15:8];
		end
	end

	// R2 window limit high
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioLimitHigh_r <= bridge_header_ctrl_pkg::RST_IO_LIMIT_HIGH;
		end else if (wrIo) begin
			if (cfgByteEn[2]) ioLimitHigh_r[7:0]  <= cfgWrData[23:16];
			if (cfgByteEn[3]) ioLimitHigh_r[15:8] <= cfgWrData[31:24];
		end
	end

	// R14 interrupt line storage
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			intLine_r <= bridge_header_ctrl_pkg::RST_INT_LINE;
		end else if (wrIntBr && cfgByteEn[0]) begin
			intLine_r <= cfgWrData[7:0];
		end
	end

	// R4 pin byte, only the sideband load may change it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			intPin_r <= bridge_header_ctrl_pkg::RST_INT_PIN;
		end else if (pinLoadValid) begin
			intPin_r <= pinLoadValue;
		end
	end

	// control bits in byte 2; byte 3 holds only hardwired and reserved bits
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			poisonResp_r <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
			errFwd_r     <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
			isaEn_r      <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
			vgaEn_r      <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
			vgaDec16_r   <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
			secReset_r   <= bridge_header_ctrl_pkg::RST_CTRL_BIT;
		end else if (wrIntBr && cfgByteEn[2]) begin
			poisonResp_r <= cfgWrData[bridge_header_ctrl_pkg::BIT_POISON_RESP];
			errFwd_r     <= cfgWrData[bridge_header_ctrl_pkg::BIT_ERR_FWD];
			isaEn_r      <= cfgWrData[bridge_header_ctrl_pkg::BIT_ISA_EN];
			vgaEn_r      <= cfgWrData[bridge_header_ctrl_pkg::BIT_VGA_EN];
			vgaDec16_r   <= cfgWrData[bridge_header_ctrl_pkg::BIT_VGA_DEC16];
			secReset_r   <= cfgWrData[bridge_header_ctrl_pkg::BIT_SEC_RESET];
		end
	end

	// ***********************************************
	// read path
	// ***********************************************
	// R13 R15 hardwired zeros fall out of the zero default
	always_comb begin
		ctrlWord = 32'h0000_0000;
		ctrlWord[bridge_header_ctrl_pkg::BIT_POISON_RESP] = poisonResp_r;
		ctrlWord[bridge_header_ctrl_pkg::BIT_ERR_FWD]     = errFwd_r;
		ctrlWord[bridge_header_ctrl_pkg::BIT_ISA_EN]      = isaEn_r;
		ctrlWord[bridge_header_ctrl_pkg::BIT_VGA_EN]      = vgaEn_r;
		ctrlWord[bridge_header_ctrl_pkg::BIT_VGA_DEC16]   = vgaDec16_r;
		ctrlWord[bridge_header_ctrl_pkg::BIT_SEC_RESET]   = secReset_r;
		ctrlWord[15:0] = {intPin_r, intLine_r};
	end

	// address decode; unmapped offsets read zero
	always_comb begin
		if (cfgAddr == bridge_header_ctrl_pkg::OFF_IO_WINDOW_HIGH) begin
			rdData_nxt = {ioLimitHigh_r, ioBaseHigh_r};
		end else if (cfgAddr == bridge_header_ctrl_pkg::OFF_CAP_POINTER) begin
			// R3 fixed pointer
			rdData_nxt = {24'h00_0000, bridge_header_ctrl_pkg::RST_CAP_POINTER};
		end else if (cfgAddr == bridge_header_ctrl_pkg::OFF_INT_BRIDGE) begin
			rdData_nxt = ctrlWord;
		end else begin
			rdData_nxt = 32'h0000_0000;
		end
	end

	// one-cycle answer, data registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgAck    <= 1'b0;
			cfgRdData <= 32'h0000_0000;
		end else begin
			cfgAck <= cfgReq;
			if (cfgReq && !cfgWrite) cfgRdData <= rdData_nxt;
		end
	end

	// ***********************************************
	// forwarding decode
	// ***********************************************
	logic [31:0] winBase;
	logic [31:0] winLimit;
	logic        inWindow;
	logic        low64k;
	logic        isaAlias;
	logic        vgaIoHit;
	logic [9:0]  lowTen;

	assign winBase  = {ioBaseHigh_r, ioBaseLow};
	assign winLimit = {ioLimitHigh_r, ioLimitLow};
	assign inWindow = (ioReqAddr >= winBase) && (ioReqAddr <= winLimit);
	assign low64k   = (ioReqAddr[31:16] == bridge_header_ctrl_pkg::IO_LOW64K_TOP);
	assign isaAlias = low64k && (ioReqAddr[9:8] != bridge_header_ctrl_pkg::ISA_ALIAS_LOW);
	assign lowTen   = ioReqAddr[9:0];

	// R9 R10 vga i/o match; 10-bit decode ignores bits 15..10
	always_comb begin
		vgaIoHit = low64k &&
			(((lowTen >= bridge_header_ctrl_pkg::VGA_IO_A_LOW) && (lowTen <= bridge_header_ctrl_pkg::VGA_IO_A_HIGH)) ||
			 ((lowTen >= bridge_header_ctrl_pkg::VGA_IO_B_LOW) && (lowTen <= bridge_header_ctrl_pkg::VGA_IO_B_HIGH)));
		if (vgaDec16_r && (ioReqAddr[15:10] != 6'h00)) vgaIoHit = 1'b0;
	end

	// R7 R9 i/o direction, vga claim wins over isa alias
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioForwardDown <= 1'b0;
			ioForwardUp   <= 1'b0;
		end else begin
			ioForwardDown <= ioReqValid && ((vgaEn_r && vgaIoHit) || (inWindow && !(isaEn_r && isaAlias)));
			ioForwardUp   <= ioReqValid && inWindow && isaEn_r && isaAlias && !(vgaEn_r && vgaIoHit);
		end
	end

	// R8 legacy video memory
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			vgaMemForward <= 1'b0;
		end else begin
			vgaMemForward <= memReqValid && vgaEn_r && (memReqAddr >= bridge_header_ctrl_pkg::VGA_MEM_LOW) &&
				(memReqAddr <= bridge_header_ctrl_pkg::VGA_MEM_HIGH);
		end
	end

	// R5 R6 event gating, one pulse per event
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			poisonReport  <= 1'b0;
			errMsgForward <= 1'b0;
		end else begin
			poisonReport  <= poisonedSeen && poisonResp_r;
			errMsgForward <= errMsgSeen && errFwd_r;
		end
	end

	// R11 R12 hot reset fan-out; held while the bit stays set
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hotResetReq     <= 1'b0;
			downPortReset_n <= '1;
		end else begin
			hotResetReq     <= secReset_r;
			downPortReset_n <= (secReset_r && isUpstreamPort) ? '0 : '1;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	// checks ride on the one clock and go quiet while reset is held
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence ctrlWrite(int b);
		wrIntBr && cfgByteEn[2] && cfgWrData[b];
	endsequence

	sequence ctrlReadBack;
		cfgReq && !cfgWrite && (cfgAddr == bridge_header_ctrl_pkg::OFF_INT_BRIDGE);
	endsequence

	io_base_write_a: assert property (wrIo && (cfgByteEn[1:0] == 2'b11) // R1
		|=> ioBaseHigh_r == $past(cfgWrData[15:0]))
		else $error("io base high not stored");
	io_limit_write_a: assert property (wrIo && (cfgByteEn[3:2] == 2'b11) // R2
		|=> ioLimitHigh_r == $past(cfgWrData[31:16]))
		else $error("io limit high not stored");
	cap_ptr_read_a: assert property (cfgReq && !cfgWrite && cfgAddr == bridge_header_ctrl_pkg::OFF_CAP_POINTER
		|=> cfgAck && cfgRdData == 32'h0000_0040) // R3
		else $error("capability pointer wrong");
	pin_write_blocked_a: assert property (wrIntBr && !pinLoadValid |=> $stable(intPin_r)) // R4
		else $error("pin byte changed by host write");
	poison_gate_a: assert property (poisonedSeen && !poisonResp_r |=> !poisonReport) // R5
		else $error("poisoned reported while disabled");
	err_fwd_a: assert property (errMsgSeen && errFwd_r |=> errMsgForward) // R6
		else $error("error message not forwarded");
	isa_up_a: assert property (ioReqValid && inWindow && isaEn_r && isaAlias && !vgaEn_r |=> ioForwardUp && !ioForwardDown) // R7
		else $error("isa alias not sent upstream");
	vga_mem_a: assert property (memReqValid && !vgaEn_r |=> !vgaMemForward) // R8
		else $error("vga memory forwarded while off");
	vga_io_a: assert property (ioReqValid && vgaEn_r && low64k && // R9
		(!vgaDec16_r || ioReqAddr[15:10] == 6'h00) &&
		(((lowTen >= bridge_header_ctrl_pkg::VGA_IO_A_LOW) && (lowTen <= bridge_header_ctrl_pkg::VGA_IO_A_HIGH)) ||
		((lowTen >= bridge_header_ctrl_pkg::VGA_IO_B_LOW) && (lowTen <= bridge_header_ctrl_pkg::VGA_IO_B_HIGH)))
		|=> ioForwardDown)
		else $error("vga io not forwarded");
	vga_dec16_a: assert property (ioReqValid && vgaEn_r && vgaDec16_r && isaEn_r && isaAlias && // R10
		ioReqAddr[15:10] != 6'h00 |=> !ioForwardDown)
		else $error("16-bit vga decode aliased");
	hot_reset_a: assert property (ctrlWrite(bridge_header_ctrl_pkg::BIT_SEC_RESET) |=> ##1 hotResetReq) // R11
		else $error("hot reset not raised");
	down_reset_a: assert property (secReset_r && isUpstreamPort |=> downPortReset_n == '0) // R12
		else $error("downstream resets not asserted");
	legacy_zero_a: assert property (ctrlReadBack |=> cfgRdData[27:23] == 5'h00 && !cfgRdData[21]) // R13
		else $error("legacy bit read non-zero");
	rsvd_zero_a: assert property (ctrlReadBack |=> cfgRdData[31:28] == 4'h0) // R15
		else $error("reserved bits read non-zero");
	line_write_a: assert property (wrIntBr && cfgByteEn[0] |=> intLine_r == $past(cfgWrData[7:0])) // R14
		else $error("interrupt line lost");

endmodule // bridge_header_ctrl_regs

`default_nettype wire

// file: hdl/bridge_header_ctrl_pkg.sv
/*
 * constants for the bridge header control registers: offsets, field positions,
 * reset values and forwarding decode bounds.
 * assumes byte addresses into the configuration header, dword aligned.
 */
`default_nettype none

package bridge_header_ctrl_pkg;

	// ***********************************************
	// register offsets
	// ***********************************************
	localparam logic [7:0] OFF_IO_WINDOW_HIGH = 8'h30;
	localparam logic [7:0] OFF_CAP_POINTER    = 8'h34;
	localparam logic [7:0] OFF_INT_BRIDGE     = 8'h3C;

	// ***********************************************
	// reset values
	// ***********************************************
	localparam logic [15:0] RST_IO_BASE_HIGH  = 16'h0000;
	localparam logic [15:0] RST_IO_LIMIT_HIGH = 16'h0000;
	localparam logic [7:0]  RST_CAP_POINTER   = 8'h40;
	localparam logic [7:0]  RST_INT_LINE      = 8'h00;
	localparam logic [7:0]  RST_INT_PIN       = 8'h00;
	localparam logic        RST_CTRL_BIT      = 1'b0;

	// ***********************************************
	// bridge control bit positions in the 3Ch word
	// ***********************************************
	localparam int BIT_POISON_RESP = 16;
	localparam int BIT_ERR_FWD     = 17;
	localparam int BIT_ISA_EN      = 18;
	localparam int BIT_VGA_EN      = 19;
	localparam int BIT_VGA_DEC16   = 20;
	localparam int BIT_SEC_RESET   = 22;

	// ***********************************************
	// forwarding decode bounds
	// ***********************************************
	localparam logic [31:0] VGA_MEM_LOW   = 32'h000A_0000;
	localparam logic [31:0] VGA_MEM_HIGH  = 32'h000B_FFFF;
	localparam logic [9:0]  VGA_IO_A_LOW  = 10'h3B0;
	localparam logic [9:0]  VGA_IO_A_HIGH = 10'h3BB;
	localparam logic [9:0]  VGA_IO_B_LOW  = 10'h3C0;
	localparam logic [9:0]  VGA_IO_B_HIGH = 10'h3DF;
	// first 64KB of i/o space: address bits 31..16 all zero
	localparam logic [15:0] IO_LOW64K_TOP = 16'h0000;
	// top 768 bytes of each 1KB block have bits 9..8 non-zero
	localparam logic [1:0]  ISA_ALIAS_LOW = 2'h0;

	localparam int NUM_DOWN_PORTS = 3;

endpackage

`default_nettype wire

// file: test/cfg_host_model.sv
/*
 * upstream host model: issues single configuration reads and writes.
 * assumes the register bank acks each request with a one-cycle pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module cfg_host_model (
	// clock
	input  wire logic        core_clk,
	// request side
	output logic             cfgReq,
	output logic             cfgWrite,
	output logic [7:0]       cfgAddr,
	output logic [3:0]       cfgByteEn,
	output logic [31:0]      cfgWrData,
	// answer side
	input  wire logic        cfgAck,
	input  wire logic [31:0] cfgRdData
);
	// idle cycles before each request, so the host can be slow
	int waitDelay = 0;

	// bus idle at time zero
	initial begin
		cfgReq = 1'b0;
		cfgWrite = 1'b0;
		cfgAddr = 8'h00;
		cfgByteEn = 4'h0;
		cfgWrData = 32'h0000_0000;
	end

	// ***********************************************
	// one access
	// ***********************************************
	// request pulses for one cycle; address, byte enables and data stay put until the ack is seen or 8 polls pass, then are scrambled
	task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] data, output logic [31:0] rd, output logic ok);
		ok = 1'b0;
		rd = 32'h0000_0000;
		repeat (waitDelay) @(posedge core_clk);
		@(posedge core_clk);
		#1;
		cfgReq = 1'b1;
		cfgWrite = wr;
		cfgAddr = addr;
		cfgByteEn = be;
		cfgWrData = data;
		@(posedge core_clk);
		#1;
		cfgReq = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			if (cfgAck === 1'b1) begin
				ok = 1'b1;
				rd = cfgRdData;
			end else begin
				@(posedge core_clk);
				#1;
			end
		end
		// released lines must not look like held data
		cfgAddr = ~addr;
		cfgWrData = ~data;
		cfgByteEn = ~be;
	endtask
endmodule // cfg_host_model

`default_nettype wire

// file: test/test_bridge_header_ctrl_regs.sv
/*
 * self-checking bench for the bridge header control registers.
 * assumes cfg_host_model drives the config port; the rest is driven here.
 */
`timescale 1ns/10ps
`default_nettype none

module test_bridge_header_ctrl_regs;
	localparam int TB_PERIOD = 40;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cfgReq, cfgWrite, cfgAck;
	logic [7:0] cfgAddr;
	logic [3:0] cfgByteEn;
	logic [31:0] cfgWrData, cfgRdData;
	logic pinLoadValid = 1'b0, isUpstreamPort = 1'b0, ioReqValid = 1'b0, memReqValid = 1'b0;
	logic [7:0] pinLoadValue = 8'h00;
	logic [15:0] ioBaseLow = 16'h0000, ioLimitLow = 16'h0000;
	logic [31:0] ioReqAddr = 32'h0000_0000, memReqAddr = 32'h0000_0000;
	logic poisonedSeen = 1'b0, errMsgSeen = 1'b0;
	logic ioForwardDown, ioForwardUp, vgaMemForward, poisonReport, errMsgForward, hotResetReq;
	logic [2:0] downPortReset_n;
	// reference model state and scratch
	logic [31:0] m30 = 32'h0000_0000, mCtl = 32'h0000_0000, rnd = 32'h0000_5e60, a, m, rd;
	logic [7:0] mLine = 8'h00, mPin = 8'h00;
	logic [1:0] e;
	int miscompares = 0, nChecks = 0;

	always #(TB_PERIOD/2) core_clk = ~core_clk;

	cfg_host_model host (.core_clk(core_clk), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
		.cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgAck(cfgAck), .cfgRdData(cfgRdData));
	bridge_header_ctrl_regs uut (.core_clk(core_clk), .arst_n(arst_n), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
		.cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgAck(cfgAck),
		.cfgRdData(cfgRdData), .pinLoadValid(pinLoadValid), .pinLoadValue(pinLoadValue),
		.isUpstreamPort(isUpstreamPort), .ioBaseLow(ioBaseLow), .ioLimitLow(ioLimitLow),
		.ioReqValid(ioReqValid), .ioReqAddr(ioReqAddr), .memReqValid(memReqValid),
		.memReqAddr(memReqAddr), .ioForwardDown(ioForwardDown), .ioForwardUp(ioForwardUp),
		.vgaMemForward(vgaMemForward), .poisonedSeen(poisonedSeen), .errMsgSeen(errMsgSeen),
		.poisonReport(poisonReport), .errMsgForward(errMsgForward), .hotResetReq(hotResetReq),
		.downPortReset_n(downPortReset_n));

	// ***********************************************
	// helpers
	// ***********************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected {up, down}; a video hit wins over alias and window
	function automatic logic [1:0] ioExp(input logic [31:0] x);
		logic win, low, vga;
		win = (x >= {m30[15:0], ioBaseLow}) && (x <= {m30[31:16], ioLimitLow});
		low = (x[31:16] == 16'h0000);
		vga = mCtl[19] && low && (!mCtl[20] || x[15:10] == 6'h00) &&
			((x[9:0] >= 10'h3B0 && x[9:0] <= 10'h3BB) || (x[9:0] >= 10'h3C0 && x[9:0] <= 10'h3DF));
		if (vga)
			return 2'b01;
		if (win && mCtl[18] && low && x[9:8] != 2'b00)
			return 2'b10;
		return {1'b0, win};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rw(input logic wr, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
		logic ok;
		host.access(wr, ad, be, d, rd, ok);
		chk({31'h0, ok}, 32'h0000_0001, "ack");
	endtask

	task automatic rdChk(input logic [7:0] ad, input logic [31:0] exp);
		rw(1'b0, ad, 4'h0, rnd);
		chk(rd, exp, "read");
	endtask

	task automatic completeRun();
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		#(TB_PERIOD * 20000);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		completeRun();
	end

	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		chk({29'h0, downPortReset_n}, 32'h0000_0007, "port reset idle");
		rdChk(8'h30, 32'h0000_0000);
		rdChk(8'h34, 32'h0000_0040);
		rdChk(8'h3C, 32'h0000_0000);
		rdChk(8'h38, 32'h0000_0000);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			host.waitDelay = int'(rnd[5:4]);
			rw(1'b1, 8'h30, rnd[3:0], lfsr(rnd));
			m = lfsr(rnd);
			for (int b = 0; b < 4; b++)
				if (rnd[b]) m30[8*b +: 8] = m[8*b +: 8];
			rdChk(8'h30, m30);
		end
		host.waitDelay = 0;
		$display("test window halves done");
		rw(1'b1, 8'h3C, 4'hF, 32'hFFFF_FFFF);
		mLine = 8'hFF;
		rdChk(8'h3C, 32'h005F_FFFF & 32'hFFFF_00FF);
		rw(1'b1, 8'h34, 4'hF, 32'h0000_0000);
		rdChk(8'h34, 32'h0000_0040);
		rnd = lfsr(rnd);
		@(posedge core_clk);
		#1;
		pinLoadValid = 1'b1;
		pinLoadValue = rnd[7:0];
		mPin = rnd[7:0];
		@(posedge core_clk);
		#1;
		pinLoadValid = 1'b0;
		rdChk(8'h3C, {16'h005F, mPin, mLine});
		$display("test control word done");
		for (int up = 0; up < 2; up++) begin
			isUpstreamPort = up[0];
			rw(1'b1, 8'h3C, 4'b0100, 32'h0040_0000);
			@(posedge core_clk);
			#1;
			chk({31'h0, hotResetReq}, 32'h0000_0001, "hot reset");
			chk({29'h0, downPortReset_n}, up ? 32'h0000_0000 : 32'h0000_0007, "port reset");
			rw(1'b1, 8'h3C, 4'b0100, 32'h0000_0000);
			@(posedge core_clk);
			#1;
			chk({31'h0, hotResetReq}, 32'h0000_0000, "hot reset off");
			chk({29'h0, downPortReset_n}, 32'h0000_0007, "port reset off");
		end
		$display("test hot reset done");
		rw(1'b1, 8'h30, 4'hF, 32'h0001_0000);
		m30 = 32'h0001_0000;
		ioBaseLow = 16'h0100;
		ioLimitLow = 16'hFFFF;
		for (int i = 0; i < 256; i++) begin
			rnd = lfsr(rnd);
			if (i % 4 == 0) begin
				mCtl = rnd & 32'h001F_0000;
				rw(1'b1, 8'h3C, 4'b0100, mCtl);
				rnd = lfsr(rnd);
			end
			a = rnd & 32'h0001_FFFF;
			if (rnd[21])
				a[9:0] = 10'h3B0 + {5'h00, rnd[26:22]};
			m = lfsr(rnd) & 32'h000F_FFFF;
			@(posedge core_clk);
			#1;
			{ioReqValid, memReqValid, ioReqAddr, memReqAddr} = {2'b11, a, m};
			{poisonedSeen, errMsgSeen} = rnd[28:27];
			@(posedge core_clk);
			#1;
			{ioReqValid, memReqValid, poisonedSeen, errMsgSeen} = 4'h0;
			e = ioExp(a);
			chk({30'h0, ioForwardUp, ioForwardDown}, {30'h0, e}, "io decode");
			chk({31'h0, vgaMemForward}, {31'h0, mCtl[19] && m >= 32'h000A_0000 && m <= 32'h000B_FFFF}, "vga mem");
			chk({31'h0, poisonReport}, {31'h0, mCtl[16] && rnd[28]}, "poison");
			chk({31'h0, errMsgForward}, {31'h0, mCtl[17] && rnd[27]}, "err msg");
		end
		$display("test decode and events done");
		completeRun();
	end
endmodule // test_bridge_header_ctrl_regs

`default_nettype wire
